// ==== ufl_defines.svh ====
// register offsets, reset values and frame counts for the frame/loop control block
`ifndef UFL_DEFINES_SVH
`define UFL_DEFINES_SVH

// register byte offsets
`define UFL_OFF_FRAME_CTRL 8'h00
`define UFL_OFF_AUX_CTRL   8'h04
`define UFL_OFF_STATUS     8'h08
`define UFL_OFF_DATA       8'h0C
`define UFL_OFF_BIT_PERIOD 8'h10

// reset values
`define UFL_RST_FRAME_CTRL 8'h00
`define UFL_RST_AUX_CTRL   5'h00
`define UFL_RST_BIT_PERIOD 16'h01B2

// status bit positions
`define UFL_ST_RX_FULL 0
`define UFL_ST_PAR_ERR 1
`define UFL_ST_FRM_ERR 2
`define UFL_ST_IDLE    3
`define UFL_ST_TX_BUSY 4

// character and idle counts
`define UFL_LAST_BIT_8 4'h7
`define UFL_LAST_BIT_9 4'h8
`define UFL_IDLE_BITS_8 4'hA
`define UFL_IDLE_BITS_9 4'hB

`endif

// ==== ufl_pkg.sv ====
// types shared by the frame/loop control block
`default_nettype none
package ufl_pkg;

  // first control register, bit 7 down to bit 0
  typedef struct packed {
    logic loop_select;
    logic wait_clock_freeze;
    logic receiver_source_select;
    logic nine_bit_select;
    logic wake_addr_mark;
    logic idle_type_select;
    logic parity_enable;
    logic parity_odd_select;
  } ufl_frame_ctrl_t;

  // auxiliary control register, bit 4 down to bit 0
  typedef struct packed {
    logic tx_bit8;
    logic rx_wake_standby;
    logic single_wire_out_dir;
    logic tx_on;
    logic rx_on;
  } ufl_aux_ctrl_t;

  // transmit pin drive pair
  typedef struct packed {
    logic oe;
    logic out;
  } ufl_txd_drive_t;

  typedef enum logic [3:0] {
    UFL_IDLE  = 4'h1,
    UFL_START = 4'h2,
    UFL_DATA  = 4'h4,
    UFL_STOP  = 4'h8
  } ufl_state_t;

endpackage : ufl_pkg
`default_nettype wire

// ==== ufl_core.sv ====
// serial transceiver with frame, loop and parity control behind a wishbone slave
//
// Behaviour
// R1: loop clear: separate receive and transmit pins
// R2: loop set: transmitter feeds receiver internally
// R3: loop set: receive pin unused
// R4: source select ignored while loop clear
// R5: loop, source clear: internal loopback only
// R6: loop, source set: single wire on transmit pin
// R7: freeze clear: clocks run in wait
// R8: freeze set: clocks stop in wait
// R9: eight-bit mode: start, 8 data, stop
// R10: nine-bit mode: start, 9 data, stop
// R11: wake bit picks idle or address-mark
// R12: idle count after start or stop bit
// R13: idle type set ignores stop, trailing ones
// R14: parity enabled: generate, check, MSB is parity
// R15: parity disabled: no generation or check
// R16: parity type: 0 even, 1 odd
// R17: control register read/write, resets to zero
// R18: loop set releases receive pin to port
// R19: direction bit steers single-wire transmit pin
// R20: mismatching received parity flags an error
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`include "ufl_defines.svh"
`default_nettype none
module ufl_core (
  // clock, reset and enable
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  // processor wait state
  input  wire logic                  cpu_wait,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic                       wb_ack_o,
  output logic [31:0]                wb_dat_o,
  // serial pins
  input  wire logic                  rxd_pin_i,
  input  wire logic                  txd_pin_i,
  output ufl_pkg::ufl_txd_drive_t    txd_drive_o,
  output logic                       rxd_pin_used_o
);
  import ufl_pkg::*;

  ufl_frame_ctrl_t frame_reg;
  ufl_aux_ctrl_t   aux_reg;
  logic [15:0]     period_reg;
  logic            rx_full_reg, par_err_reg, frm_err_reg, idle_flag_reg;
  logic [8:0]      rx_data_reg;
  logic            rxd_s1_reg, rxd_s2_reg, txd_s1_reg, txd_s2_reg;
  ufl_state_t      tx_state, rx_state;
  logic [15:0]     tx_cnt, rx_cnt;
  logic [3:0]      tx_idx, rx_idx, idle_cnt;
  logic [8:0]      tx_shift, rx_shift;
  logic            tx_line_reg, rx_prev_reg, idle_armed_reg;
  logic            run, acc, wr, rd_fire, tx_load, tx_tick, rx_tick, rx_half;
  logic            rx_line, rx_done, rx_msb, rx_perr, rx_accept, idle_hit;
  logic [3:0]      last_bit, idle_need;
  logic [31:0]     rd_next;

  function automatic logic at_off(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : at_off

  // parity over the data bits below the character's top bit
  function automatic logic par_bit(input logic [8:0] d, input logic nine, input logic odd);
    return (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction : par_bit

  // state advances only while enabled and not frozen by wait
  assign run = clk_en & ~(cpu_wait & frame_reg.wait_clock_freeze); // [R7] [R8]

  // bus strobes: writes and read side effects land on the edge the master sees ack
  assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = clk_en & wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign rd_fire = clk_en & wb_cyc_i & wb_stb_i & ~wb_we_i & wb_ack_o;

  assign last_bit  = frame_reg.nine_bit_select ? `UFL_LAST_BIT_9 : `UFL_LAST_BIT_8; // [R9] [R10]
  assign idle_need = frame_reg.nine_bit_select ? `UFL_IDLE_BITS_9 : `UFL_IDLE_BITS_8;
  assign tx_tick   = run & (tx_cnt == period_reg - 16'h0001);
  assign rx_tick   = run & (rx_cnt == period_reg - 16'h0001);
  assign rx_half   = run & (rx_cnt == {1'b0, period_reg[15:1]});
  assign tx_load   = run & wr & at_off(wb_adr_i, `UFL_OFF_DATA) & aux_reg.tx_on
                     & (tx_state == UFL_IDLE);

  // receiver input source
  always_comb begin
    if (!frame_reg.loop_select) begin
      rx_line = rxd_s2_reg; // [R1] [R4]
    end else if (!frame_reg.receiver_source_select) begin
      rx_line = tx_line_reg; // [R2] [R5]
    end else if (aux_reg.single_wire_out_dir) begin
      rx_line = tx_line_reg; // [R6]
    end else begin
      rx_line = txd_s2_reg; // [R6] [R19]
    end
  end

  // pin synchronisers; the receive pin is ignored in loop modes by the mux above
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      txd_s1_reg <= 1'b1;
      txd_s2_reg <= 1'b1;
    end else if (clk_en) begin
      rxd_s1_reg <= rxd_pin_i;
      rxd_s2_reg <= rxd_s1_reg;
      txd_s1_reg <= txd_pin_i;
      txd_s2_reg <= txd_s1_reg;
    end
  end

  // ack one cycle after the request is seen
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= acc;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (at_off(wb_adr_i, `UFL_OFF_FRAME_CTRL)) begin
      rd_next[7:0] = frame_reg; // [R17]
    end else if (at_off(wb_adr_i, `UFL_OFF_AUX_CTRL)) begin
      rd_next[4:0] = aux_reg;
    end else if (at_off(wb_adr_i, `UFL_OFF_STATUS)) begin
      rd_next[`UFL_ST_RX_FULL] = rx_full_reg;
      rd_next[`UFL_ST_PAR_ERR] = par_err_reg;
      rd_next[`UFL_ST_FRM_ERR] = frm_err_reg;
      rd_next[`UFL_ST_IDLE]    = idle_flag_reg;
      rd_next[`UFL_ST_TX_BUSY] = (tx_state != UFL_IDLE);
    end else if (at_off(wb_adr_i, `UFL_OFF_DATA)) begin
      rd_next[8:0] = rx_data_reg;
    end else if (at_off(wb_adr_i, `UFL_OFF_BIT_PERIOD)) begin
      rd_next[15:0] = period_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en && acc) begin
      wb_dat_o <= rd_next;
    end
  end

  // first control register, plain read/write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_reg <= `UFL_RST_FRAME_CTRL; // [R17]
    end else if (wr && at_off(wb_adr_i, `UFL_OFF_FRAME_CTRL)) begin
      frame_reg <= ufl_frame_ctrl_t'(wb_dat_i[7:0]); // [R17]
    end
  end

  // auxiliary control; wakeup clears standby in hardware
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aux_reg <= `UFL_RST_AUX_CTRL;
    end else if (wr && at_off(wb_adr_i, `UFL_OFF_AUX_CTRL)) begin
      aux_reg <= ufl_aux_ctrl_t'(wb_dat_i[4:0]);
    end else if (aux_reg.rx_wake_standby && frame_reg.wake_addr_mark && rx_done && rx_msb) begin
      aux_reg.rx_wake_standby <= 1'b0; // [R11]
    end else if (aux_reg.rx_wake_standby && !frame_reg.wake_addr_mark && idle_hit) begin
      aux_reg.rx_wake_standby <= 1'b0; // [R11]
    end
  end

  // bit period; a value below two cycles is not meaningful
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      period_reg <= `UFL_RST_BIT_PERIOD;
    end else if (wr && at_off(wb_adr_i, `UFL_OFF_BIT_PERIOD)) begin
      period_reg <= wb_dat_i[15:0];
    end
  end

  // transmitter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_state    <= UFL_IDLE;
      tx_cnt      <= 16'h0000;
      tx_idx      <= 4'h0;
      tx_shift    <= 9'h000;
      tx_line_reg <= 1'b1;
    end else if (tx_load) begin
      tx_shift <= {aux_reg.tx_bit8, wb_dat_i[7:0]}; // [R15]
      if (frame_reg.parity_enable && frame_reg.nine_bit_select) begin
        tx_shift[8] <= par_bit({1'b0, wb_dat_i[7:0]}, 1'b1, frame_reg.parity_odd_select); // [R14] [R16]
      end else if (frame_reg.parity_enable) begin
        tx_shift[7] <= par_bit({1'b0, wb_dat_i[7:0]}, 1'b0, frame_reg.parity_odd_select); // [R14] [R16]
      end
      tx_state    <= UFL_START;
      tx_cnt      <= 16'h0000;
      tx_line_reg <= 1'b0;
    end else if (run && tx_state != UFL_IDLE) begin
      tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
      if (tx_tick) begin
        case (tx_state)
          UFL_START: begin
            tx_state    <= UFL_DATA;
            tx_idx      <= 4'h0;
            tx_line_reg <= tx_shift[0];
            tx_shift    <= {1'b0, tx_shift[8:1]};
          end
          UFL_DATA: begin
            if (tx_idx == last_bit) begin
              tx_state    <= UFL_STOP; // [R9] [R10]
              tx_line_reg <= 1'b1;
            end else begin
              tx_idx      <= tx_idx + 4'h1;
              tx_line_reg <= tx_shift[0];
              tx_shift    <= {1'b0, tx_shift[8:1]};
            end
          end
          default: begin
            tx_state <= UFL_IDLE;
          end
        endcase
      end
    end
  end

  // pin drive: single-wire mode listens on the pin unless the direction bit is set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txd_drive_o    <= '0;
      rxd_pin_used_o <= 1'b0;
    end else if (clk_en) begin
      txd_drive_o.out <= tx_line_reg;
      txd_drive_o.oe  <= aux_reg.tx_on & (~(frame_reg.loop_select
                         & frame_reg.receiver_source_select)
                         | aux_reg.single_wire_out_dir); // [R19] [R6] [R1]
      rxd_pin_used_o  <= aux_reg.rx_on & ~frame_reg.loop_select; // [R3] [R18]
    end
  end

  // end-of-character decode
  assign rx_done   = rx_tick & (rx_state == UFL_STOP);
  assign rx_msb    = frame_reg.nine_bit_select ? rx_shift[8] : rx_shift[7];
  assign rx_perr   = frame_reg.parity_enable &
                     (par_bit(rx_shift, frame_reg.nine_bit_select,
                              frame_reg.parity_odd_select) != rx_msb); // [R14] [R15] [R16]
  assign rx_accept = rx_done & (~aux_reg.rx_wake_standby | (frame_reg.wake_addr_mark & rx_msb));

  // receiver; the start bit is confirmed at its middle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_state    <= UFL_IDLE;
      rx_cnt      <= 16'h0000;
      rx_idx      <= 4'h0;
      rx_shift    <= 9'h000;
      rx_prev_reg <= 1'b1;
    end else if (run) begin
      rx_prev_reg <= rx_line;
      rx_cnt      <= rx_tick ? 16'h0000 : rx_cnt + 16'h0001;
      case (rx_state)
        UFL_IDLE: begin
          if (aux_reg.rx_on && rx_prev_reg && !rx_line) begin
            rx_state <= UFL_START;
            rx_cnt   <= 16'h0000;
          end
        end
        UFL_START: begin
          if (rx_half) begin
            rx_state <= rx_line ? UFL_IDLE : UFL_DATA;
            rx_cnt   <= 16'h0000;
            rx_idx   <= 4'h0;
          end
        end
        UFL_DATA: begin
          if (rx_tick) begin
            rx_shift[rx_idx] <= rx_line;
            rx_idx           <= rx_idx + 4'h1;
            if (rx_idx == last_bit) begin
              rx_state <= UFL_STOP; // [R9] [R10]
            end
          end
        end
        default: begin
          if (rx_tick) begin
            rx_state <= UFL_IDLE;
          end
        end
      endcase
    end
  end

  // received data and status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_data_reg   <= 9'h000;
      rx_full_reg   <= 1'b0;
      par_err_reg   <= 1'b0;
      frm_err_reg   <= 1'b0;
      idle_flag_reg <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_data_reg <= frame_reg.nine_bit_select ? rx_shift : {1'b0, rx_shift[7:0]};
      end
      rx_full_reg <= rx_accept |
                     (rx_full_reg & ~(rd_fire & at_off(wb_adr_i, `UFL_OFF_DATA)));
      if (rx_accept || (wr && at_off(wb_adr_i, `UFL_OFF_STATUS))) begin
        par_err_reg <= (rx_accept & rx_perr) |
                       (par_err_reg & ~(wr & wb_dat_i[`UFL_ST_PAR_ERR])); // [R20]
        frm_err_reg <= (rx_accept & ~rx_line) |
                       (frm_err_reg & ~(wr & wb_dat_i[`UFL_ST_FRM_ERR]));
      end
      idle_flag_reg <= idle_hit |
                       (idle_flag_reg & ~(wr & at_off(wb_adr_i, `UFL_OFF_STATUS)
                                          & wb_dat_i[`UFL_ST_IDLE]));
    end
  end

  assign idle_hit = run & idle_armed_reg & (idle_cnt >= idle_need);

  // idle-line counter: high bit times, from the start bit or only after the stop bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt       <= 4'h0;
      idle_armed_reg <= 1'b0;
    end else if (run) begin
      if (rx_state == UFL_START) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_hit) begin
        idle_armed_reg <= 1'b0;
      end
      if (rx_state == UFL_START || !aux_reg.rx_on) begin
        idle_cnt <= 4'h0; // [R12]
      end else if (rx_tick) begin
        if (rx_state == UFL_IDLE || !frame_reg.idle_type_select) begin
          idle_cnt <= !rx_line ? 4'h0 : (idle_cnt == 4'hF ? idle_cnt : idle_cnt + 4'h1); // [R12]
        end else begin
          idle_cnt <= 4'h0; // [R13]
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_frame_write;
    wr && at_off(wb_adr_i, `UFL_OFF_FRAME_CTRL) |=> frame_reg == $past(wb_dat_i[7:0]);
  endproperty
  a_frame_write: assert property (p_frame_write) else $error("frame control write lost"); // [R17]

  property p_rx_pin_free;
    clk_en && frame_reg.loop_select |=> !rxd_pin_used_o;
  endproperty
  a_rx_pin_free: assert property (p_rx_pin_free) else $error("rx pin kept in loop"); // [R3] [R18]

  property p_normal_oe;
    clk_en && !frame_reg.loop_select |=> txd_drive_o.oe == $past(aux_reg.tx_on);
  endproperty
  a_normal_oe: assert property (p_normal_oe) else $error("tx pin drive wrong in normal mode"); // [R1] [R4]

  property p_single_listen;
    clk_en && frame_reg.loop_select && frame_reg.receiver_source_select
      && !aux_reg.single_wire_out_dir |=> !txd_drive_o.oe;
  endproperty
  a_single_listen: assert property (p_single_listen) else $error("single wire pin driven"); // [R6] [R19]

  property p_freeze;
    cpu_wait && frame_reg.wait_clock_freeze |=> $stable(tx_cnt) && $stable(rx_cnt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counters moved while frozen"); // [R8]

  property p_wait_runs;
    clk_en && cpu_wait && !frame_reg.wait_clock_freeze |=> rx_cnt != $past(rx_cnt);
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("receiver stalled in wait"); // [R7]

  property p_char_len;
    tx_tick && tx_state == UFL_DATA && tx_idx == (frame_reg.nine_bit_select ? 4'h8 : 4'h7)
      |=> tx_state == UFL_STOP && tx_line_reg;
  endproperty
  a_char_len: assert property (p_char_len) else $error("wrong data bit count"); // [R9] [R10]

  property p_tx_parity;
    tx_load && frame_reg.parity_enable |=>
      (frame_reg.nine_bit_select ? ^tx_shift : ^tx_shift[7:0]) == frame_reg.parity_odd_select;
  endproperty
  a_tx_parity: assert property (p_tx_parity) else $error("generated parity wrong"); // [R14] [R16]

  property p_tx_raw;
    tx_load && !frame_reg.parity_enable |=> tx_shift[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_tx_raw: assert property (p_tx_raw) else $error("data altered without parity"); // [R15]

  property p_par_flag;
    rx_accept && rx_perr |=> par_err_reg;
  endproperty
  a_par_flag: assert property (p_par_flag) else $error("parity error not flagged"); // [R20]

  property p_idle_wake;
    idle_hit && aux_reg.rx_wake_standby && !frame_reg.wake_addr_mark && !wr |=> !aux_reg.rx_wake_standby;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wakeup missed"); // [R11]

  property p_ilt_frame;
    rx_tick && frame_reg.idle_type_select && rx_state == UFL_DATA |=> idle_cnt == 4'h0;
  endproperty
  a_ilt_frame: assert property (p_ilt_frame) else $error("idle counted inside frame"); // [R12] [R13]

endmodule : ufl_core
`default_nettype wire

// ==== ufl_remote_node.sv ====
// remote serial node model that sits on the line side of the transceiver
`default_nettype none
module ufl_remote_node #(
  parameter int PERIOD = 4
) (
  // clock
  input  wire logic mclk,
  // line as the node sees it, frame length, own drive
  input  wire logic line_in,
  input  wire logic nine,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int         n_got = 0;
  logic [8:0] got   = 9'h000;

  initial line_out = 1'b1;

  // receiver: sample each bit in its middle, lsb first, 8 or 9 data bits
  always begin
    @(negedge line_in);
    got = 9'h000;
    repeat (PERIOD + PERIOD / 2) @(posedge mclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      got[i] = line_in;
      repeat (PERIOD) @(posedge mclk);
    end
    n_got++;
  end

  // sender: start low, data lsb first, one stop high; line then rests high
  task automatic send(input logic [8:0] w);
    int n;
    n = nine ? 10 : 9;
    for (int i = 0; i <= n; i++) begin
      line_out <= (i == 0) ? 1'b0 : ((i == n) ? 1'b1 : w[i - 1]);
      repeat (PERIOD) @(posedge mclk);
    end
  endtask : send
endmodule : ufl_remote_node
`default_nettype wire

// ==== tb_uart_frame_loop_control.sv ====
// self-checking bench for the frame, loop and parity control block
`include "ufl_defines.svh"
`default_nettype none
module tb_uart_frame_loop_control;
  timeunit 1ns;
  timeprecision 1ps;
  import ufl_pkg::*;

  localparam int BIT_P = 4;  // short bit time keeps eight-bit frames at 40 cycles, nine-bit at 44

  logic           mclk        = 1'b0;
  logic           nrst        = 1'b0;
  logic           clk_en      = 1'b1;
  logic           cpu_wait    = 1'b0;
  logic           wb_cyc      = 1'b0;
  logic           wb_stb      = 1'b0;
  logic           wb_we       = 1'b0;
  logic [7:0]     wb_adr      = 8'h00;
  logic [3:0]     wb_sel      = 4'h0;
  logic [3:0]     sel_use     = 4'hF;
  logic [31:0]    wb_wdat     = 32'h0;
  logic           node_on_txd = 1'b0;
  logic           node_nine   = 1'b0;
  logic           wb_ack;
  logic [31:0]    wb_rdat;
  logic           node_out;
  logic           rxd_used;
  ufl_txd_drive_t txd_drive;
  wire            txd_line;
  wire            rxd_line;
  int             err_count   = 0;
  int             n_checks    = 0;
  int             cycles      = 0;
  int             toggles     = 0;
  int             t0;
  logic [31:0]    rd;

  // an undriven shared pin rests high, as an idle line with pull-up would
  assign txd_line = txd_drive.oe ? txd_drive.out : (node_on_txd ? node_out : 1'b1);
  assign rxd_line = node_on_txd ? 1'b1 : node_out;

  ufl_core dut (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .cpu_wait(cpu_wait),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat),
    .rxd_pin_i(rxd_line), .txd_pin_i(txd_line), .txd_drive_o(txd_drive),
    .rxd_pin_used_o(rxd_used)
  );

  ufl_remote_node #(.PERIOD(BIT_P)) node (
    .mclk(mclk), .line_in(txd_line), .nine(node_nine), .line_out(node_out)
  );

  initial begin
    forever #10 mclk = ~mclk;
  end

  // hang guard: a full run needs well under this many cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // counts every movement of the level the core drives toward the transmit pin
  always @(txd_drive.out) toggles++;

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; ack and read data are taken at the rising edge that shows ack
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge mclk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel_use;
    wb_wdat <= dat;
    do begin
      @(posedge mclk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask : rdc

  // send one byte and compare what the remote node saw on the transmit pin
  task automatic tx_expect(input logic [7:0] v, input logic [8:0] exp);
    int n0;
    n0 = node.n_got;
    xfer(1'b1, `UFL_OFF_DATA, {24'h0, v});
    while (node.n_got == n0) @(posedge mclk);
    repeat (2 * BIT_P) @(posedge mclk);  // let the stop bit and busy flag finish
    check({23'h0, node.got}, {23'h0, exp});
  endtask : tx_expect

  // poll for a received character, then read it (reading clears rx full)
  task automatic rx_expect(input logic [8:0] exp);
    rd = 32'h0;
    while (rd[`UFL_ST_RX_FULL] !== 1'b1) begin
      xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    end
    xfer(1'b0, `UFL_OFF_DATA, 32'h0);
    check(rd, {23'h0, exp});
  endtask : rx_expect

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rdc(`UFL_OFF_FRAME_CTRL, 32'h0);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'hFF);
    rdc(`UFL_OFF_FRAME_CTRL, 32'hFF);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h5A);
    rdc(`UFL_OFF_FRAME_CTRL, 32'h5A);
    rdc(8'h40, 32'h0);
    // byte lane zero off, or an unmapped address: the write is dropped
    sel_use = 4'hE;
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'hFFFF_FFFF);
    sel_use = 4'h1;
    xfer(1'b1, 8'hA0, 32'h0000_00FF);
    sel_use = 4'hF;
    rdc(`UFL_OFF_FRAME_CTRL, 32'h5A);
    rdc(`UFL_OFF_BIT_PERIOD, 32'h1B2);
    xfer(1'b1, `UFL_OFF_BIT_PERIOD, 32'(BIT_P));
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h03);
    // normal two-pin mode, source select set but without meaning here
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h20);
    repeat (2) @(posedge mclk);
    check({31'h0, rxd_used}, 32'h1);
    tx_expect(8'hA5, 9'h0A5);
    node.send(9'h03C);
    rx_expect(9'h03C);
    // internal loopback while the node talks on the receive pin
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h80);
    repeat (2) @(posedge mclk);
    check({31'h0, rxd_used}, 32'h0);
    fork
      node.send(9'h00F);
      xfer(1'b1, `UFL_OFF_DATA, 32'h5A);
    join
    rx_expect(9'h05A);
    // single wire: drive out, then listen on the transmit pin
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h07);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'hA0);
    repeat (2) @(posedge mclk);
    check({31'h0, txd_drive.oe}, 32'h1);
    tx_expect(8'h96, 9'h096);
    rx_expect(9'h096);
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h03);
    repeat (2) @(posedge mclk);
    check({31'h0, txd_drive.oe}, 32'h0);
    node_on_txd <= 1'b1;
    node.send(9'h069);
    rx_expect(9'h069);
    node_on_txd <= 1'b0;
    // parity: msb replaced on transmit, checked on receive
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h02);
    tx_expect(8'h01, 9'h081);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h03);
    tx_expect(8'h01, 9'h001);
    node.send(9'h081);
    rx_expect(9'h081);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h17, 32'h02);
    xfer(1'b1, `UFL_OFF_STATUS, 32'h02);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h00);
    tx_expect(8'h01, 9'h001);
    node.send(9'h081);
    rx_expect(9'h081);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h17, 32'h00);
    // idle line: high bits count from the start bit, or only after the stop bit
    xfer(1'b1, `UFL_OFF_STATUS, 32'h08);
    node.send(9'h0FF);
    rx_expect(9'h0FF);
    repeat (2 * BIT_P) @(posedge mclk);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h08, 32'h08);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h04);
    xfer(1'b1, `UFL_OFF_STATUS, 32'h08);
    node.send(9'h0FF);
    rx_expect(9'h0FF);
    repeat (2 * BIT_P) @(posedge mclk);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h08, 32'h00);
    repeat (10 * BIT_P) @(posedge mclk);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h08, 32'h08);
    // idle-line wakeup: standby drops the character, the idle line ends standby
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h00);
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h0B);
    node.send(9'h0FF);
    repeat (14 * BIT_P) @(posedge mclk);
    rdc(`UFL_OFF_AUX_CTRL, 32'h03);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h01, 32'h00);
    // nine-bit characters, plain and with parity in bit 8
    node_nine <= 1'b1;
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h10);
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h13);
    tx_expect(8'h55, 9'h155);
    node.send(9'h1AA);
    rx_expect(9'h1AA);
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h12);
    tx_expect(8'h00, 9'h000);
    node_nine <= 1'b0;
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h03);
    // wait freeze set: a frame in flight stalls while the processor waits
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h40);
    xfer(1'b1, `UFL_OFF_DATA, 32'h33);
    repeat (12) @(posedge mclk);
    cpu_wait <= 1'b1;
    repeat (2) @(posedge mclk);
    t0 = toggles;
    repeat (100) @(posedge mclk);
    check(32'(toggles - t0), 32'h0);
    cpu_wait <= 1'b0;
    // clock enable low holds the same frame just as firmly
    clk_en   <= 1'b0;
    repeat (2) @(posedge mclk);
    t0 = toggles;
    repeat (50) @(posedge mclk);
    check(32'(toggles - t0), 32'h0);
    clk_en <= 1'b1;
    repeat (200) @(posedge mclk);
    // wait freeze clear: clocks keep running in wait
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h00);
    cpu_wait <= 1'b1;
    tx_expect(8'h44, 9'h044);
    cpu_wait <= 1'b0;
    // address-mark wakeup: standby drops a character whose msb is clear
    xfer(1'b1, `UFL_OFF_FRAME_CTRL, 32'h08);
    xfer(1'b1, `UFL_OFF_AUX_CTRL, 32'h0B);
    node.send(9'h012);
    repeat (2 * BIT_P) @(posedge mclk);
    xfer(1'b0, `UFL_OFF_STATUS, 32'h0);
    check(rd & 32'h01, 32'h00);
    node.send(9'h092);
    rx_expect(9'h092);
    // reset in mid-run clears the first control register again
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rdc(`UFL_OFF_FRAME_CTRL, 32'h0);
    tally_and_finish();
  end
endmodule : tb_uart_frame_loop_control
`default_nettype wire
